/* common/charger_emulation_stimulus_params.svh */
// Offsets, field positions, reset values and timing counts of the stimulus stage
`ifndef CHARGER_EMULATION_STIMULUS_PARAMS_SVH
`define CHARGER_EMULATION_STIMULUS_PARAMS_SVH

`define ADDR_STAGE1_DIVIDER_RATIO      8'h34
`define ADDR_STAGE2_TIMER_AND_STIMULUS 8'h35
`define ADDR_STAGE2_RESPONSE_AND_MAG   8'h36

`define RST_STAGE1_DIVIDER_RATIO       8'h00
`define RST_STAGE2_TIMER_AND_STIMULUS  8'h00
`define RST_STAGE2_RESPONSE_AND_MAG    8'h00
`define RST_STAGE2_COMPARE_THRESHOLD   4'h0
`define RST_STAGE2_SINK_CURRENT        2'h0

`define POS_TIMER_MODE                 6
`define POS_TIMER_DUR_HI               5
`define POS_TIMER_DUR_LO               3
`define POS_TRIG_SEL_HI                2
`define POS_TRIG_SEL_LO                0
`define POS_MAG_HI                     7
`define POS_MAG_LO                     4
`define POS_CODE_HI                    3
`define POS_CODE_LO                    0
`define POS_RATIO_HI                   2
`define POS_RATIO_LO                   0

`define RATIO_RESERVED                 3'h7
`define MAG_RESERVED                   4'hf

`define TRIG_VBUS_READY                3'h0
`define TRIG_PLUS_ABOVE                3'h1
`define TRIG_PLUS_WINDOW               3'h2
`define TRIG_MINUS_ABOVE               3'h3
`define TRIG_PLUS_ABOVE_ALT            3'h6
`define TRIG_VBUS_PRESENT              3'h7

`define REF_CLK_PERIOD_NS              8
`define TIMER_TICK_MS                  1
`define NS_PER_MS                      1000000

`endif

/* common/charger_emulation_stimulus_pkg.sv */
// Types shared by the stimulus stage logic
package charger_emulation_stimulus_pkg;

  typedef enum logic [2:0] {
    PIN_OPEN,
    PIN_PD15K,
    PIN_VOLT,
    PIN_RES_GND,
    PIN_DIVIDER
  } pin_act_t;

  typedef struct packed {
    pin_act_t plus;
    pin_act_t minus;
    logic     bridge;
  } pin_drive_t;

  typedef enum logic [1:0] {
    MAG_NONE,
    MAG_VOLTAGE,
    MAG_RESISTOR,
    MAG_DIVIDER
  } mag_class_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DELAY,
    ST_HOLD,
    ST_RELEASE
  } stage_state_t;

endpackage

/* hw/charger_emulation_stimulus_cfg.sv */
// Stage-2 stimulus/response engine with its read-only configuration registers
//
// What this block does
// RQ1: Stage-1 divider response uses 3-bit ratio field, 0.25 to 0.66, 111 reserved.
// RQ2: Divider ratio is not updated when a BC1.2 profile is applied.
// RQ3: Timer mode 1 applies response at once, holds it, removes once stimulus gone.
// RQ4: Timer mode 0 waits the timer duration after the stimulus, then responds.
// RQ5: Timer duration field 000..111 means 0,1,5,10,20,40,80,100 ms.
// RQ6: Select 000 is bus voltage ready; next stage does not wait for removal.
// RQ7: Selects 001 and 110 detect plus pin above threshold, 011 minus pin.
// RQ8: Select 010 is window comparator on plus pin, below threshold above 400 mV.
// RQ9: Select 111 is bus voltage present; no wait for removal; 100, 101 reserved.
// RQ10: A reserved magnitude code is rejected and the field keeps its value.
// RQ11: Voltage responses decode magnitude to pull-down or 400 to 2200 mV.
// RQ12: Resistor responses decode magnitude from 1.8 kilohm up to 150 kilohm.
// RQ13: Divider responses decode magnitude as minimum total divider resistance.
// RQ14: Code 0000 clears both pins; 0001, 0010, 0011 apply voltage plus, minus, both.
// RQ15: Resistor to ground on plus, minus or both; 1010 bridges the pins.
// RQ16: Codes 0110, 1001, 1100 place a bus divider on plus, minus or both.
// RQ17: Codes 1110, 1111 keep, remove or leave the reset pull-downs by select.
// RQ18: Single-pin responses keep the other pin's reset pull-down only if stage-1 select is 000.
// RQ19: Threshold field decodes 300 to 2200 mV, ignored for selects 000 and 111.
// RQ20: Pull-down magnitude sinks 10, 50, 100 or 150 microamps by 2-bit field.
// RQ21: Settings come from the active profile; host writes are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "charger_emulation_stimulus_params.svh"

module charger_emulation_stimulus_cfg
  import charger_emulation_stimulus_pkg::*;
#(
  parameter int CYCLES_PER_MS = (`TIMER_TICK_MS * `NS_PER_MS) / `REF_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire  logic       ref_clk,
  input  wire  logic       arst_n,
  // Register access
  input  wire  logic       regRdEn,
  input  wire  logic       regWrEn,
  input  wire  logic [7:0] regAddr,
  input  wire  logic [7:0] regWrData,
  output var   logic [7:0] regRdData,
  // Profile loading
  input  wire  logic       profLoad,
  input  wire  logic       profIsBc12,
  input  wire  logic [7:0] profRatio,
  input  wire  logic [7:0] profTimerStim,
  input  wire  logic [7:0] profRespMag,
  input  wire  logic [3:0] profThreshold,
  input  wire  logic [1:0] profSink,
  // Sequence control
  input  wire  logic       emuReset,
  input  wire  logic       stageStart,
  input  wire  logic [2:0] stage1_trigger_select,
  input  wire  logic [3:0] stage1_response_code,
  // Stimulus sources
  input  wire  logic       vbusReady,
  input  wire  logic       vbusPresent,
  input  wire  logic       plusAboveTh,
  input  wire  logic       plusAboveFloor,
  input  wire  logic       minusAboveTh,
  // Pin drive and status
  output var   pin_drive_t pinDrive,
  output var   logic       respActive,
  output var   logic       stageDone,
  // Decoded settings for the analog side
  output var   mag_class_t magClass,
  output var   logic [11:0] magValue,
  output var   logic [11:0] thresholdMv,
  output var   logic       thresholdUsed,
  output var   logic [7:0] sinkUa,
  output var   logic [6:0] ratioPct,
  output var   logic       stage1RatioValid
);

  logic [2:0]   stage1_divider_ratio_sel;
  logic         stage2_timer_mode;
  logic [2:0]   stage2_timer_duration;
  logic [2:0]   stage2_trigger_select;
  logic [3:0]   stage2_response_magnitude;
  logic [3:0]   stage2_response_code;
  logic [3:0]   stage2_compare_threshold;
  logic [1:0]   stage2_sink_current;
  stage_state_t state;
  logic [31:0]  prescale;
  logic         msTick;
  logic [6:0]   msCount;
  logic         stimHit;
  logic         vbusTrig;
  logic         timerDone;
  pin_drive_t   savedDrive;
  pin_drive_t   appliedDrive;

  function automatic mag_class_t classOf(input logic [3:0] c);
    unique case (c)
      4'h0, 4'h1, 4'h2, 4'h3:        classOf = MAG_VOLTAGE;
      4'h4, 4'h7, 4'hd, 4'he, 4'hf:  classOf = MAG_RESISTOR;
      4'h6, 4'h9, 4'hc:              classOf = MAG_DIVIDER;
      default:                       classOf = MAG_NONE;
    endcase
  endfunction

  function automatic logic [6:0] timerMs(input logic [2:0] d);
    unique case (d)
      3'h0: timerMs = 7'h00;
      3'h1: timerMs = 7'h01;
      3'h2: timerMs = 7'h05;
      3'h3: timerMs = 7'h0a;
      3'h4: timerMs = 7'h14;
      3'h5: timerMs = 7'h28;
      3'h6: timerMs = 7'h50;
      3'h7: timerMs = 7'h64;
    endcase
  endfunction

  // Voltage in mV, resistor in 100 ohm units, divider in kilohm
  function automatic logic [11:0] magDecode(input mag_class_t k, input logic [3:0] m);
    logic [11:0] v;
    v = 12'h000;
    unique case (k)
      MAG_VOLTAGE: begin
        unique case (m)
          4'h0:                   v = 12'h000;
          4'h1, 4'h2, 4'h3, 4'h4: v = 12'h190;
          4'h5: v = 12'h1f4;
          4'h6: v = 12'h258;
          4'h7: v = 12'h2bc;
          4'h8: v = 12'h320;
          4'h9: v = 12'h384;
          4'ha: v = 12'h578;
          4'hb: v = 12'h640;
          4'hc: v = 12'h708;
          4'hd: v = 12'h7d0;
          4'he: v = 12'h898;
          4'hf: v = 12'h000;
        endcase
      end
      MAG_RESISTOR: begin
        unique case (m)
          4'h0: v = 12'h012;
          4'h1: v = 12'h064;
          4'h2: v = 12'h096;
          4'h3: v = 12'h0c8;
          4'h4: v = 12'h0fa;
          4'h5: v = 12'h12c;
          4'h6: v = 12'h190;
          4'h7: v = 12'h1ae;
          4'h8: v = 12'h1f4;
          4'h9: v = 12'h258;
          4'ha: v = 12'h2ee;
          4'hb: v = 12'h320;
          4'hc: v = 12'h3e8;
          4'hd: v = 12'h4b0;
          4'he: v = 12'h5dc;
          4'hf: v = 12'h000;
        endcase
      end
      MAG_DIVIDER: begin
        // Lower four codes repeat from 1000
        unique case (m[2:0])
          3'h0:    v = 12'h05d;
          3'h1:    v = 12'h064;
          3'h2:    v = 12'h07d;
          3'h3:    v = 12'h096;
          default: v = 12'h0c8;
        endcase
        if (m[3] && m[2])
          v = 12'h0c8;
        if (m == `MAG_RESERVED)
          v = 12'h000;
      end
      MAG_NONE: v = 12'h000;
    endcase
    magDecode = v;
  endfunction

  function automatic logic [11:0] thDecode(input logic [3:0] t);
    unique case (t)
      4'h3:    thDecode = 12'h12c;
      4'h5:    thDecode = 12'h1f4;
      4'h6:    thDecode = 12'h258;
      4'h7:    thDecode = 12'h2bc;
      4'h8:    thDecode = 12'h320;
      4'h9:    thDecode = 12'h384;
      4'ha:    thDecode = 12'h578;
      4'hb:    thDecode = 12'h640;
      4'hc:    thDecode = 12'h708;
      4'hd:    thDecode = 12'h7d0;
      4'he:    thDecode = 12'h898;
      4'hf:    thDecode = 12'h000;
      default: thDecode = 12'h190;
    endcase
  endfunction

  // RQ18 other pin pull-down
  // Drop a reset pull-down unless stage 1 waited on bus-ready
  function automatic pin_act_t otherPin(input pin_act_t p, input logic [2:0] s1);
    otherPin = (p == PIN_PD15K && s1 != `TRIG_VBUS_READY) ? PIN_OPEN : p;
  endfunction

  // RQ14 RQ15 RQ16 RQ17 response pin drive
  function automatic pin_drive_t applyResp(input logic [3:0] c, input pin_drive_t cur,
                                           input logic [2:0] s1, input logic [2:0] s2);
    pin_drive_t n;
    n = cur;
    unique case (c)
      4'h0: n = '{plus: PIN_OPEN, minus: PIN_OPEN, bridge: 1'b0};
      4'h1: n = '{plus: PIN_VOLT, minus: otherPin(cur.minus, s1), bridge: cur.bridge};
      4'h2: n = '{plus: otherPin(cur.plus, s1), minus: PIN_VOLT, bridge: cur.bridge};
      4'h3: n = '{plus: PIN_VOLT, minus: PIN_VOLT, bridge: cur.bridge};
      4'h4: n = '{plus: PIN_RES_GND, minus: otherPin(cur.minus, s1), bridge: cur.bridge};
      4'h7: n = '{plus: otherPin(cur.plus, s1), minus: PIN_RES_GND, bridge: cur.bridge};
      4'hd: n = '{plus: PIN_RES_GND, minus: PIN_RES_GND, bridge: cur.bridge};
      4'ha: n.bridge = 1'b1;
      4'h6: n = '{plus: PIN_DIVIDER, minus: otherPin(cur.minus, s1), bridge: cur.bridge};
      4'h9: n = '{plus: otherPin(cur.plus, s1), minus: PIN_DIVIDER, bridge: cur.bridge};
      4'hc: n = '{plus: PIN_DIVIDER, minus: PIN_DIVIDER, bridge: cur.bridge};
      4'he, 4'hf: begin
        if (s2 == `TRIG_VBUS_PRESENT) begin
          n.plus  = (cur.plus == PIN_PD15K) ? PIN_OPEN : cur.plus;
          n.minus = (cur.minus == PIN_PD15K) ? PIN_OPEN : cur.minus;
        end
      end
      default: n = cur;
    endcase
    applyResp = n;
  endfunction

  // RQ21 profile load only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage2_timer_mode         <= 1'(`RST_STAGE2_TIMER_AND_STIMULUS >> `POS_TIMER_MODE);
      stage2_timer_duration     <= 3'h0;
      stage2_trigger_select     <= 3'h0;
      stage2_response_code      <= 4'h0;
      stage2_response_magnitude <= 4'h0;
    end else if (profLoad) begin
      stage2_timer_mode     <= profTimerStim[`POS_TIMER_MODE];
      stage2_timer_duration <= profTimerStim[`POS_TIMER_DUR_HI:`POS_TIMER_DUR_LO];
      stage2_trigger_select <= profTimerStim[`POS_TRIG_SEL_HI:`POS_TRIG_SEL_LO];
      stage2_response_code  <= profRespMag[`POS_CODE_HI:`POS_CODE_LO];
      // RQ10 reserved magnitude
      if (profRespMag[`POS_MAG_HI:`POS_MAG_LO] != `MAG_RESERVED)
        stage2_response_magnitude <= profRespMag[`POS_MAG_HI:`POS_MAG_LO];
    end
  end

  // RQ2 legacy-only ratio
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_divider_ratio_sel <= 3'h0;
    end else if (profLoad && !profIsBc12 && profRatio[`POS_RATIO_HI:`POS_RATIO_LO] != `RATIO_RESERVED) begin
      stage1_divider_ratio_sel <= profRatio[`POS_RATIO_HI:`POS_RATIO_LO];
    end
  end

  // Threshold and sink current belong to the BC1.2 profiles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage2_compare_threshold <= `RST_STAGE2_COMPARE_THRESHOLD;
      stage2_sink_current      <= `RST_STAGE2_SINK_CURRENT;
    end else if (profLoad && profIsBc12) begin
      stage2_compare_threshold <= profThreshold;
      stage2_sink_current      <= profSink;
    end
  end

  // Read-only registers; writes fall away, unmapped reads give zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        `ADDR_STAGE1_DIVIDER_RATIO:      regRdData <= {5'h00, stage1_divider_ratio_sel};
        `ADDR_STAGE2_TIMER_AND_STIMULUS: regRdData <= {1'b0, stage2_timer_mode, stage2_timer_duration,
                                                       stage2_trigger_select};
        `ADDR_STAGE2_RESPONSE_AND_MAG:   regRdData <= {stage2_response_magnitude, stage2_response_code};
        default:                         regRdData <= 8'h00;
      endcase
    end
  end

  // RQ7 RQ8 stimulus select
  always_comb begin
    unique case (stage2_trigger_select)
      `TRIG_VBUS_READY:                      stimHit = vbusReady;
      `TRIG_PLUS_ABOVE, `TRIG_PLUS_ABOVE_ALT: stimHit = plusAboveTh;
      `TRIG_PLUS_WINDOW:                     stimHit = !plusAboveTh && plusAboveFloor;
      `TRIG_MINUS_ABOVE:                     stimHit = minusAboveTh;
      `TRIG_VBUS_PRESENT:                    stimHit = vbusPresent;
      default:                               stimHit = 1'b0;
    endcase
  end

  // RQ6 RQ9 no wait on bus stimuli
  assign vbusTrig  = (stage2_trigger_select == `TRIG_VBUS_READY) ||
                     (stage2_trigger_select == `TRIG_VBUS_PRESENT);
  assign timerDone = (msCount >= timerMs(stage2_timer_duration));
  assign appliedDrive = applyResp(stage2_response_code, pinDrive, stage1_trigger_select,
                                  stage2_trigger_select);

  // Millisecond enable; restarts with each timed phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale <= 32'h0;
      msTick   <= 1'b0;
    end else if (state == ST_WAIT || state == ST_IDLE || prescale == 32'(CYCLES_PER_MS - 1)) begin
      prescale <= 32'h0;
      msTick   <= (state == ST_DELAY || state == ST_HOLD);
    end else begin
      prescale <= prescale + 32'h1;
      msTick   <= 1'b0;
    end
  end

  // RQ5 duration count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      msCount <= 7'h00;
    else if (state == ST_WAIT || state == ST_IDLE)
      msCount <= 7'h00;
    else if (msTick && !timerDone)
      msCount <= msCount + 7'h01;
  end

  // RQ3 RQ4 sequencing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      pinDrive   <= '{plus: PIN_OPEN, minus: PIN_OPEN, bridge: 1'b0};
      savedDrive <= '{plus: PIN_OPEN, minus: PIN_OPEN, bridge: 1'b0};
      respActive <= 1'b0;
      stageDone  <= 1'b0;
    end else if (emuReset) begin
      state      <= ST_IDLE;
      pinDrive   <= '{plus: PIN_PD15K, minus: PIN_PD15K, bridge: 1'b0};
      respActive <= 1'b0;
      stageDone  <= 1'b0;
    end else begin
      stageDone <= 1'b0;
      unique case (state)
        ST_IDLE: if (stageStart) state <= ST_WAIT;
        ST_WAIT: begin
          if (stimHit && stage2_timer_mode) begin
            savedDrive <= pinDrive;
            pinDrive   <= appliedDrive;
            respActive <= 1'b1;
            state      <= ST_HOLD;
          end else if (stimHit) begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (timerDone) begin
            pinDrive   <= appliedDrive;
            respActive <= 1'b1;
            stageDone  <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_HOLD: if (timerDone) state <= ST_RELEASE;
        ST_RELEASE: begin
          if (!stimHit || vbusTrig) begin
            pinDrive   <= savedDrive;
            respActive <= 1'b0;
            stageDone  <= 1'b1;
            state      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // RQ11 RQ12 RQ13 RQ19 RQ20 RQ1 decoded settings
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      magClass         <= MAG_NONE;
      magValue         <= 12'h000;
      thresholdMv      <= 12'h000;
      thresholdUsed    <= 1'b0;
      sinkUa           <= 8'h00;
      ratioPct         <= 7'h00;
      stage1RatioValid <= 1'b0;
    end else begin
      magClass      <= classOf(stage2_response_code);
      magValue      <= magDecode(classOf(stage2_response_code), stage2_response_magnitude);
      thresholdMv   <= thDecode(stage2_compare_threshold);
      thresholdUsed <= !vbusTrig;
      unique case (stage2_sink_current)
        2'h0: sinkUa <= 8'h0a;
        2'h1: sinkUa <= 8'h32;
        2'h2: sinkUa <= 8'h64;
        2'h3: sinkUa <= 8'h96;
      endcase
      unique case (stage1_divider_ratio_sel)
        3'h0: ratioPct <= 7'h19;
        3'h1: ratioPct <= 7'h21;
        3'h2: ratioPct <= 7'h28;
        3'h3: ratioPct <= 7'h32;
        3'h4: ratioPct <= 7'h36;
        3'h5: ratioPct <= 7'h3c;
        3'h6: ratioPct <= 7'h42;
        3'h7: ratioPct <= 7'h00;
      endcase
      stage1RatioValid <= (classOf(stage1_response_code) == MAG_DIVIDER);
    end
  end

  property p_ro_write;
    @(posedge ref_clk) disable iff (!arst_n)
      regWrEn && !profLoad |=> $stable(stage2_response_code) && $stable(stage2_trigger_select);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("host write changed a setting"); // RQ21

  property p_ratio_bc12;
    @(posedge ref_clk) disable iff (!arst_n)
      profLoad && profIsBc12 |=> $stable(stage1_divider_ratio_sel);
  endproperty
  a_ratio_bc12: assert property (p_ratio_bc12) else $error("ratio changed under BC1.2"); // RQ2

  property p_mag_reject;
    @(posedge ref_clk) disable iff (!arst_n)
      profLoad && profRespMag[7:4] == 4'hf |=> $stable(stage2_response_magnitude);
  endproperty
  a_mag_reject: assert property (p_mag_reject) else $error("reserved magnitude taken"); // RQ10

  property p_immediate;
    @(posedge ref_clk) disable iff (!arst_n)
      state == ST_WAIT && stimHit && stage2_timer_mode && !emuReset |=> respActive && state == ST_HOLD;
  endproperty
  a_immediate: assert property (p_immediate) else $error("hold response not immediate"); // RQ3

  property p_delay;
    @(posedge ref_clk) disable iff (!arst_n)
      state == ST_WAIT && stimHit && !stage2_timer_mode && !emuReset |=> state == ST_DELAY && $stable(pinDrive);
  endproperty
  a_delay: assert property (p_delay) else $error("delayed response applied early"); // RQ4

  property p_window;
    @(posedge ref_clk) disable iff (!arst_n)
      state == ST_WAIT && stage2_trigger_select == 3'h2 && (plusAboveTh || !plusAboveFloor) && !emuReset
      |=> state == ST_WAIT;
  endproperty
  a_window: assert property (p_window) else $error("window hit outside window"); // RQ8

  property p_vbus_nowait;
    @(posedge ref_clk) disable iff (!arst_n)
      state == ST_RELEASE && (stage2_trigger_select == 3'h0 || stage2_trigger_select == 3'h7)
      |=> state != ST_RELEASE;
  endproperty
  a_vbus_nowait: assert property (p_vbus_nowait) else $error("waited on bus stimulus"); // RQ6 RQ9

  property p_clear;
    @(posedge ref_clk) disable iff (!arst_n)
      state == ST_WAIT && stimHit && stage2_timer_mode && stage2_response_code == 4'h0 && !emuReset
      |=> pinDrive.plus == PIN_OPEN && pinDrive.minus == PIN_OPEN && !pinDrive.bridge;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a pin driven"); // RQ14

endmodule
`default_nettype wire

/* verif/portable_device_model.sv */
// Attached portable device model driving the data-pin comparator results
`timescale 1ns/1ps
`default_nettype none
module portable_device_model (
  // Pin levels chosen by the bench, stage threshold
  input  wire logic        attached,
  input  wire logic [11:0] plusMv,
  input  wire logic [11:0] minusMv,
  input  wire logic [11:0] thMv,
  // Comparator results
  output var  logic        plusAboveTh,
  output var  logic        plusAboveFloor,
  output var  logic        minusAboveTh
);
  // threshold and window compare
  // Detached pins sit at ground, so every comparator reads low
  always_comb begin
    plusAboveTh    = attached && (plusMv > thMv);
    plusAboveFloor = attached && (plusMv > 12'h190);
    minusAboveTh   = attached && (minusMv > thMv);
  end
endmodule
`default_nettype wire

/* verif/test_charger_emulation_stimulus_cfg.sv */
// Self-checking bench for the stimulus stage registers and engine
`timescale 1ns/1ps
`default_nettype none
module test_charger_emulation_stimulus_cfg;
  import charger_emulation_stimulus_pkg::*;
  logic ref_clk = 0, arst_n = 0, regRdEn = 0, regWrEn = 0, profLoad = 0, profIsBc12 = 0;
  logic emuReset = 0, stageStart = 0, vbusReady = 0, vbusPresent = 0, attached = 0;
  logic [7:0] regAddr = 0, regWrData = 0, profRatio = 0, profTimerStim = 0, profRespMag = 0;
  logic [3:0] profThreshold = 0, stage1_response_code = 0, m;
  logic [1:0] profSink = 0;
  logic [2:0] stage1_trigger_select = 0;
  logic [11:0] plusMv = 0, minusMv = 0, magValue, thresholdMv;
  logic [7:0] regRdData, sinkUa, e34 = 0, e35 = 0, e36 = 0;
  logic [6:0] ratioPct;
  logic plusAboveTh, plusAboveFloor, minusAboveTh, respActive, stageDone, thresholdUsed, stage1RatioValid;
  pin_drive_t pinDrive;
  mag_class_t magClass;
  int miscompares = 0, checked = 0, n, i;

  charger_emulation_stimulus_cfg #(.CYCLES_PER_MS(10)) i_charger_emulation_stimulus_cfg (.ref_clk(ref_clk),
    .arst_n(arst_n), .regRdEn(regRdEn), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .profLoad(profLoad), .profIsBc12(profIsBc12), .profRatio(profRatio),
    .profTimerStim(profTimerStim), .profRespMag(profRespMag), .profThreshold(profThreshold),
    .profSink(profSink), .emuReset(emuReset), .stageStart(stageStart),
    .stage1_trigger_select(stage1_trigger_select), .stage1_response_code(stage1_response_code),
    .vbusReady(vbusReady), .vbusPresent(vbusPresent), .plusAboveTh(plusAboveTh),
    .plusAboveFloor(plusAboveFloor), .minusAboveTh(minusAboveTh), .pinDrive(pinDrive),
    .respActive(respActive), .stageDone(stageDone), .magClass(magClass), .magValue(magValue),
    .thresholdMv(thresholdMv), .thresholdUsed(thresholdUsed), .sinkUa(sinkUa), .ratioPct(ratioPct),
    .stage1RatioValid(stage1RatioValid));
  portable_device_model i_portable_device_model (.attached(attached), .plusMv(plusMv), .minusMv(minusMv),
    .thMv(thresholdMv), .plusAboveTh(plusAboveTh), .plusAboveFloor(plusAboveFloor),
    .minusAboveTh(minusAboveTh));

  always #4 ref_clk = ~ref_clk;

  function automatic logic [11:0] vmv(input logic [3:0] c);
    logic [11:0] t[16] = '{0, 400, 400, 400, 400, 500, 600, 700, 800, 900, 1400, 1600, 1800, 2000, 2200, 0};
    return t[c];
  endfunction
  function automatic logic [6:0] pct(input logic [2:0] c);
    logic [6:0] t[8] = '{25, 33, 40, 50, 54, 60, 66, 0};
    return t[c];
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Read with a write beside it, which must have no effect
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk) {regRdEn, regWrEn, regAddr, regWrData} = {2'b11, a, 8'($urandom)};
    @(negedge ref_clk) {regRdEn, regWrEn} = 2'b00;
    chk({4'h0, regRdData}, {4'h0, e}, "read");
  endtask
  task automatic ld(input logic bc, input logic [7:0] r, ts, rm, input logic [3:0] th, input logic [1:0] sk);
    @(negedge ref_clk) {profLoad, profIsBc12, profRatio, profTimerStim, profRespMag} = {2'b10 | bc, r, ts, rm};
    {profThreshold, profSink} = {th, sk};
    if (!bc && r[2:0] != 3'h7) e34 = {5'h00, r[2:0]};
    e35 = {1'b0, ts[6:0]};
    e36 = {(rm[7:4] == 4'hf) ? e36[7:4] : rm[7:4], rm[3:0]};
    @(negedge ref_clk) profLoad = 0;
    @(negedge ref_clk);
  endtask
  task automatic pulse_start();
    @(negedge ref_clk) emuReset = 1;
    @(negedge ref_clk) emuReset = 0;
    @(negedge ref_clk) stageStart = 1;
    @(negedge ref_clk) stageStart = 0;
  endtask
  task automatic wait_act(input logic lvl);
    n = 0;
    while (respActive !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h203a377d));
    repeat (4) @(negedge ref_clk);
    arst_n = 1;
    for (i = 0; i < 4; i++) rd((i < 3) ? 8'h34 + 8'(i) : 8'h40, 8'h00);
    $display("test reset done");
    ld(0, 8'h06, 8'h00, 8'h00, 0, 0);
    for (i = 0; i < 8; i++) begin
      ld(1'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 4'($urandom), 2'($urandom));
      rd(8'h34, e34);
      rd(8'h35, e35);
      rd(8'h36, e36);
      chk(ratioPct, pct(e34[2:0]), "ratio");
    end
    $display("test random load done");
    for (i = 0; i < 16; i++) begin
      m = 4'(i);
      ld(0, 8'h07, 8'h00, {m, 4'h1}, 0, 0);
      chk(magValue, vmv(e36[7:4]), "volt mag");
      chk(magClass, MAG_VOLTAGE, "volt class");
    end
    stage1_response_code = 4'h6;
    ld(0, 8'h07, 8'h00, 8'h04, 0, 0);
    chk(magValue, 12'd18, "res mag");
    ld(0, 8'h07, 8'h00, 8'h86, 0, 0);
    chk(magValue, 12'd93, "div mag");
    chk(stage1RatioValid, 1'b1, "ratio valid");
    $display("test decode done");
    stage1_trigger_select = 3'h1;
    ld(1, 8'h00, 8'h09, 8'h21, 4'h5, 2'h3);
    chk(thresholdMv, 12'd500, "thresh");
    chk(thresholdUsed, 1'b1, "thresh used");
    chk(sinkUa, 8'd150, "sink");
    pulse_start();
    {attached, plusMv} = {1'b1, 12'd900};
    wait_act(1);
    chk(n >= 10 && n <= 14, 1'b1, "delay");
    chk(stageDone, 1'b1, "done");
    chk({pinDrive.plus, pinDrive.minus}, {PIN_VOLT, PIN_OPEN}, "mode0 pins");
    $display("test delay mode done");
    attached = 0;
    stage1_trigger_select = 3'h0;
    ld(1, 8'h00, 8'h49, 8'h31, 4'h5, 2'h0);
    pulse_start();
    attached = 1;
    wait_act(1);
    chk(n <= 3, 1'b1, "hold start");
    chk({pinDrive.plus, pinDrive.minus}, {PIN_VOLT, PIN_PD15K}, "mode1 pins");
    repeat (20) @(negedge ref_clk);
    chk(respActive, 1'b1, "held");
    plusMv = 0;
    wait_act(0);
    chk(n <= 3, 1'b1, "release");
    chk(pinDrive.plus, PIN_PD15K, "restored");
    $display("test hold mode done");
    ld(1, 8'h00, 8'h47, 8'h0a, 4'h5, 2'h0);
    chk(thresholdUsed, 1'b0, "thresh unused");
    pulse_start();
    vbusPresent = 1;
    wait_act(1);
    chk(pinDrive.bridge, 1'b1, "bridge");
    wait_act(0);
    chk(n <= 3, 1'b1, "no wait on bus");
    chk(pinDrive.bridge, 1'b0, "bridge removed");
    ld(1, 8'h00, 8'h02, 8'h00, 4'h5, 2'h0);
    pulse_start();
    plusMv = 12'd300;
    repeat (5) @(negedge ref_clk);
    chk(respActive, 1'b0, "below floor");
    plusMv = 12'd450;
    wait_act(1);
    chk(n <= 3, 1'b1, "window");
    chk({pinDrive.plus, pinDrive.minus}, {PIN_OPEN, PIN_OPEN}, "clear");
    $display("test bus and window done");
    complete_run();
  end
endmodule
`default_nettype wire
